// file: verilog/eec_enclave_entry_checker.sv
// Enclave entry checker: validates an enclave entry request and, when
// every check passes, switches the architectural state it owns.
// Assumes all request inputs come from core logic on clk_i and stay
// stable from the request until done_o.
//
// Operation
// - Jump to base plus entry offset, checked
// - Entry serializes: drain before, hold after
// - Long mode needs LMA and CS.L
// - Non-long: DS usable and not expand-down
// - Non-long: zero bases, stack B set
// - Thread structure pointer must be page aligned
// - Structure outside page cache gives page fault
// - Long mode: exit pointer must be canonical
// - Shared structure access, conflict faults
// - Page map attributes must match thread page
// - Save, FS, GS offsets page aligned
// - Reserved structure flag bits must be zero
// - Enclave must exist and be initialized
// - Current mode must match enclave mode
// - Feature enables and request mask legal
// - Opt-out requires matching exit notify flag
// - Save outside stack and frame pointers
// - Record exit pointer, save, rebuild FS/GS
// - Swap feature control with request mask
// - Trap flag handling for opt-out, opt-in
// - Suppress breakpoints per entry kind
// - Opt-out suppresses monitoring, sets status bits
`timescale 1ns/100ps
module eec_enclave_entry_checker
   import eec_pkg::*;
#(
   parameter int VA_BITS = EEC_VA_BITS
)(
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic [3:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_we_i,
   input  wire logic        reg_re_i,
   output logic [31:0]      reg_rdata_o,
   input  wire logic        entry_req_i,
   input  wire logic        drain_done_i,
   input  wire logic        exit_i,
   input  wire logic        popf_tf_i,
   input  wire logic        efer_lma_i,
   input  wire logic        cs_l_i,
   input  wire logic [63:0] cs_base_i,
   input  wire logic [31:0] cs_limit_i,
   input  wire logic        ds_unusable_i,
   input  wire logic        ds_s_i,
   input  wire logic [3:0]  ds_type_i,
   input  wire logic [63:0] ds_base_i,
   input  wire logic        es_usable_i,
   input  wire logic [63:0] es_base_i,
   input  wire logic        ss_usable_i,
   input  wire logic [63:0] ss_base_i,
   input  wire logic        ss_b_i,
   input  wire logic [63:0] tcs_ptr_i,
   input  wire logic [63:0] aep_i,
   input  wire logic [63:0] rsp_i,
   input  wire logic [63:0] rbp_i,
   input  wire logic        tf_i,
   input  wire logic [63:0] fs_base_i,
   input  wire logic [63:0] gs_base_i,
   input  wire logic        tcs_in_epc_i,
   input  wire logic        tcs_busy_i,
   input  wire logic        map_valid_i,
   input  wire logic        map_blocked_i,
   input  wire logic        map_pending_i,
   input  wire logic        map_modified_i,
   input  wire logic [63:0] map_addr_i,
   input  wire logic [7:0]  map_type_i,
   input  wire logic [63:0] save_area_off_i,
   input  wire logic [63:0] fs_base_off_i,
   input  wire logic [63:0] gs_base_off_i,
   input  wire logic [63:0] entry_off_i,
   input  wire logic [63:0] tcs_flags_i,
   input  wire logic        enclave_control_struct_present_i,
   input  wire logic        enclave_control_struct_init_i,
   input  wire logic        enclave_control_struct_wide_i,
   input  wire logic        enclave_control_struct_notify_i,
   input  wire logic [63:0] enclave_control_struct_base_i,
   input  wire logic [63:0] enclave_control_struct_feature_request_mask_i,
   input  wire logic        os_fx_save_i,
   input  wire logic        os_ext_save_i,
   input  wire logic [63:0] xcr_i,
   output logic             busy_o,
   output logic             hold_issue_o,
   output logic             tcs_share_o,
   output logic             done_o,
   output logic             fault_gp_o,
   output logic             fault_pf_o,
   output logic [63:0]      fault_addr_o,
   output logic             enclave_mode_o,
   output logic [63:0]      new_rip_o,
   output logic [63:0]      ssa_rsp_o,
   output logic [63:0]      ssa_rbp_o,
   output logic [63:0]      tcs_aep_o,
   output logic [63:0]      saved_fs_o,
   output logic [63:0]      saved_gs_o,
   output logic [63:0]      fs_base_o,
   output logic [63:0]      gs_base_o,
   output logic [63:0]      xcr_o,
   output logic [63:0]      saved_xcr_o,
   output logic             tf_o,
   output logic             saved_tf_o,
   output logic             step_pend_o,
   output logic             bp_out_supp_o,
   output logic             bp_in_supp_o,
   output logic             perf_supp_o,
   output logic             sample_off_o,
   output logic [63:0]      perf_gstat_set_o
);
   if (VA_BITS < 32 || VA_BITS > 63)
   begin : g_va_check
      $error("VA_BITS out of range");
   end

   typedef enum logic [1:0] {S_IDLE, S_DRAIN, S_CHECK} eec_state_e;

   eec_state_e  state_q;
   eec_fault_e  chk_code;
   eec_fault_e  last_code_q;
   logic        long_mode;
   logic        opt_in;
   logic        commit;
   logic        check_fail;
   logic [63:0] target;
   logic [1:0]  ctrl_q;
   logic [15:0] count_q;
   logic        last_gp_q;
   logic        last_pf_q;

   function automatic logic canon_w(input logic [63:0] a);
      canon_w = (&a[63:VA_BITS-1]) || ~(|a[63:VA_BITS-1]);
   endfunction

   assign long_mode  = efer_lma_i && cs_l_i;
   assign opt_in     = tcs_flags_i[EEC_FLAG_OPTIN];
   assign target     = enclave_control_struct_base_i + entry_off_i;
   assign check_fail = (state_q == S_CHECK) && (chk_code != FC_NONE);
   assign commit     = (state_q == S_CHECK) && (chk_code == FC_NONE);

   // Checks in flow order; the first failing one decides the fault.
   always_comb
   begin
      chk_code = FC_NONE;
      if (!ctrl_q[EEC_CTRL_ENABLE])
         chk_code = FC_DISABLED;
      else if (!long_mode && (ds_unusable_i || (ds_s_i && !ds_type_i[EEC_DS_CODE_BIT]
               && ds_type_i[EEC_DS_EXPD_BIT])))
         chk_code = FC_DS_SEG;
      else if (!long_mode && ((cs_base_i != '0) || (ds_base_i != '0)
               || (es_usable_i && es_base_i != '0)
               || (ss_usable_i && (ss_base_i != '0 || !ss_b_i))))
         chk_code = FC_SEG_BASE;
      else if (tcs_ptr_i[EEC_PAGE_BITS-1:0] != '0)
         chk_code = FC_TCS_ALIGN;
      else if (!tcs_in_epc_i)
         chk_code = FC_TCS_EPC;
      else if (long_mode && !canon_w(aep_i))
         chk_code = FC_AEP;
      else if (tcs_busy_i)
         chk_code = FC_CONFLICT;
      else if (!map_valid_i || map_blocked_i || map_pending_i || map_modified_i
               || map_addr_i != tcs_ptr_i || map_type_i != EEC_PT_THREAD)
         chk_code = FC_MAP;
      else if ((save_area_off_i[EEC_PAGE_BITS-1:0] != '0)
               || (fs_base_off_i[EEC_PAGE_BITS-1:0] != '0)
               || (gs_base_off_i[EEC_PAGE_BITS-1:0] != '0))
         chk_code = FC_OFFSETS;
      else if ((tcs_flags_i & EEC_FLAGS_RSVD) != '0)
         chk_code = FC_FLAGS;
      else if (!enclave_control_struct_present_i || !enclave_control_struct_init_i)
         chk_code = FC_ENCLAVE_CONTROL_STRUCT;
      else if (long_mode != enclave_control_struct_wide_i)
         chk_code = FC_MODE;
      else if (!os_fx_save_i
               || (ctrl_q[EEC_CTRL_XSAVE] && !os_ext_save_i && enclave_control_struct_feature_request_mask_i != EEC_FEATURE_REQUEST_MASK_LEGACY)
               || (os_ext_save_i && (enclave_control_struct_feature_request_mask_i & ~xcr_i) != '0))
         chk_code = FC_FEATURE;
      else if (!opt_in && tcs_flags_i[EEC_FLAG_NOTIFY] != enclave_control_struct_notify_i)
         chk_code = FC_NOTIFY;
      else if (long_mode ? !canon_w(target) : (target > {32'h0, cs_limit_i}))
         chk_code = FC_TARGET;
   end

   // Entry sequencing: wait for older work to drain, then check.
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         state_q <= S_IDLE;
      else
      begin
         case (state_q)
            S_IDLE:
               if (entry_req_i)
                  state_q <= S_DRAIN;
            S_DRAIN:
               if (drain_done_i)
                  state_q <= S_CHECK;
            S_CHECK:
               state_q <= S_IDLE;
            default:
               state_q <= S_IDLE;
         endcase
      end
   end

   // Issue of younger work stays held through the check cycle and drops as done_o rises.
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         busy_o       <= 1'b0;
         hold_issue_o <= 1'b0;
         tcs_share_o  <= 1'b0;
      end
      else
      begin
         busy_o       <= (state_q == S_IDLE) ? entry_req_i : (state_q != S_CHECK);
         hold_issue_o <= (state_q == S_IDLE) ? entry_req_i : (state_q != S_CHECK);
         tcs_share_o  <= (state_q == S_DRAIN) && drain_done_i;
      end
   end

   // Completion and fault pulses; nothing else changes on a fault.
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         done_o       <= 1'b0;
         fault_gp_o   <= 1'b0;
         fault_pf_o   <= 1'b0;
         fault_addr_o <= '0;
      end
      else
      begin
         done_o     <= state_q == S_CHECK;
         fault_gp_o <= check_fail && chk_code != FC_TCS_EPC && chk_code != FC_MAP;
         fault_pf_o <= check_fail && (chk_code == FC_TCS_EPC || chk_code == FC_MAP);
         if (check_fail)
            fault_addr_o <= (chk_code == FC_TCS_EPC || chk_code == FC_MAP) ? tcs_ptr_i : '0;
      end
   end

   // Architectural state switch, performed only after every check passed.
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         enclave_mode_o <= 1'b0;
         new_rip_o      <= '0;
         ssa_rsp_o      <= '0;
         ssa_rbp_o      <= '0;
         tcs_aep_o      <= '0;
         saved_fs_o     <= '0;
         saved_gs_o     <= '0;
         fs_base_o      <= '0;
         gs_base_o      <= '0;
      end
      else if (commit)
      begin
         enclave_mode_o <= 1'b1;
         new_rip_o      <= target;
         ssa_rsp_o      <= rsp_i;
         ssa_rbp_o      <= rbp_i;
         tcs_aep_o      <= aep_i;
         saved_fs_o     <= fs_base_i;
         saved_gs_o     <= gs_base_i;
         fs_base_o      <= enclave_control_struct_base_i + fs_base_off_i;
         gs_base_o      <= enclave_control_struct_base_i + gs_base_off_i;
      end
      else if (exit_i)
      begin
         enclave_mode_o <= 1'b0;
         fs_base_o      <= saved_fs_o;
         gs_base_o      <= saved_gs_o;
      end
   end

   // Extended feature control swap.
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         xcr_o       <= '0;
         saved_xcr_o <= '0;
      end
      else if (commit && os_ext_save_i)
      begin
         saved_xcr_o <= xcr_i;
         xcr_o       <= enclave_control_struct_feature_request_mask_i;
      end
      else if (exit_i && enclave_mode_o)
         xcr_o <= saved_xcr_o;
      else if (!enclave_mode_o)
         xcr_o <= xcr_i;
   end

   // Trap flag: opt-out entries hide single-stepping from the outside.
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         tf_o        <= 1'b0;
         saved_tf_o  <= 1'b0;
         step_pend_o <= 1'b0;
      end
      else
      begin
         step_pend_o <= commit && opt_in;
         if (commit)
         begin
            saved_tf_o <= tf_i;
            tf_o       <= opt_in ? tf_i : 1'b0;
         end
         else if (exit_i && enclave_mode_o)
            tf_o <= bp_in_supp_o ? saved_tf_o : tf_i;
         else if (enclave_mode_o && bp_in_supp_o && popf_tf_i)
            tf_o <= 1'b0;
         else if (!enclave_mode_o)
            tf_o <= tf_i;
      end
   end

   // Debug and monitoring suppression, held while inside the enclave.
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         bp_out_supp_o    <= 1'b0;
         bp_in_supp_o     <= 1'b0;
         perf_supp_o      <= 1'b0;
         sample_off_o     <= 1'b0;
         perf_gstat_set_o <= '0;
      end
      else
      begin
         perf_gstat_set_o <= '0;
         if (commit)
         begin
            bp_out_supp_o <= 1'b1;
            bp_in_supp_o  <= !opt_in;
            perf_supp_o   <= !opt_in;
            sample_off_o  <= !opt_in;
            if (!opt_in)
            begin
               perf_gstat_set_o[EEC_PGS_SUPP0] <= 1'b1;
               perf_gstat_set_o[EEC_PGS_SUPP1] <= 1'b1;
            end
         end
         else if (exit_i)
         begin
            bp_out_supp_o <= 1'b0;
            bp_in_supp_o  <= 1'b0;
            perf_supp_o   <= 1'b0;
            sample_off_o  <= 1'b0;
         end
      end
   end

   // Register port: control, status of the last entry, entry count.
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         ctrl_q      <= EEC_CTRL_RESET;
         count_q     <= '0;
         last_code_q <= FC_NONE;
         last_gp_q   <= 1'b0;
         last_pf_q   <= 1'b0;
      end
      else
      begin
         if (reg_we_i && reg_addr_i == EEC_REG_CTRL)
            ctrl_q <= reg_wdata_i[1:0];
         if (commit)
            count_q <= count_q + 16'h0001;
         else if (reg_we_i && reg_addr_i == EEC_REG_COUNT)
            count_q <= reg_wdata_i[15:0];
         if (state_q == S_CHECK)
         begin
            last_code_q <= chk_code;
            last_gp_q   <= check_fail && chk_code != FC_TCS_EPC && chk_code != FC_MAP;
            last_pf_q   <= chk_code == FC_TCS_EPC || chk_code == FC_MAP;
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         reg_rdata_o <= '0;
      else if (reg_re_i)
      begin
         case (reg_addr_i)
            EEC_REG_CTRL:   reg_rdata_o <= {30'h0, ctrl_q};
            EEC_REG_STATUS: reg_rdata_o <= {24'h0, last_code_q, last_pf_q, last_gp_q,
                                            enclave_mode_o, busy_o};
            EEC_REG_COUNT:  reg_rdata_o <= {16'h0, count_q};
            default:        reg_rdata_o <= '0;
         endcase
      end
      else
         reg_rdata_o <= '0;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   sequence s_start;
      state_q == S_IDLE && entry_req_i;
   endsequence
   sequence s_drained;
      state_q == S_DRAIN && drain_done_i;
   endsequence

   serial_hold_a: assert property (s_start |=> hold_issue_o)
      else $error("issue not held after entry request");
   drain_first_a: assert property (state_q == S_DRAIN && !drain_done_i |=> state_q != S_CHECK)
      else $error("checks started before drain");
   tcs_align_a: assert property (s_drained ##1 (ctrl_q[EEC_CTRL_ENABLE] && long_mode
         && tcs_ptr_i[11:0] != '0) |=> fault_gp_o && !fault_pf_o)
      else $error("misaligned structure did not fault");
   tcs_epc_a: assert property (state_q == S_CHECK && chk_code == FC_TCS_EPC
         |=> fault_pf_o && fault_addr_o == $past(tcs_ptr_i))
      else $error("page fault not raised on structure");
   conflict_gp_a: assert property (state_q == S_CHECK && chk_code == FC_CONFLICT
         |=> fault_gp_o)
      else $error("conflict did not fault");
   no_change_a: assert property ((fault_gp_o || fault_pf_o)
         |-> $stable(enclave_mode_o) && $stable(new_rip_o))
      else $error("state changed on faulting entry");
   entry_rip_a: assert property (commit |=> enclave_mode_o
         && new_rip_o == $past(target))
      else $error("wrong entry target");
   xcr_swap_a: assert property (commit && os_ext_save_i
         |=> xcr_o == $past(enclave_control_struct_feature_request_mask_i) && saved_xcr_o == $past(xcr_i))
      else $error("feature control not swapped");
   optout_perf_a: assert property (commit && !opt_in |=> perf_gstat_set_o[EEC_PGS_SUPP0]
         && perf_gstat_set_o[EEC_PGS_SUPP1] && perf_supp_o && !tf_o)
      else $error("opt-out suppression missing");
endmodule // eec_enclave_entry_checker

// file: verilog/eec_pkg.sv
// Constants, types and helpers for the enclave entry checker.
// Assumes a single 100 MHz core clock and 64-bit linear addresses.
package eec_pkg;
   localparam int          EEC_AW          = 64;
   localparam int          EEC_VA_BITS     = 48;
   localparam int          EEC_PAGE_BITS   = 12;
   localparam logic [63:0] EEC_FLAGS_RSVD  = 64'h00ff_ffff_ffff_fffc;
   localparam int          EEC_FLAG_OPTIN  = 0;
   localparam int          EEC_FLAG_NOTIFY = 1;
   localparam logic [63:0] EEC_FEATURE_REQUEST_MASK_LEGACY = 64'h0000_0000_0000_0003;
   localparam logic [7:0]  EEC_PT_THREAD   = 8'h01;
   localparam int          EEC_PGS_SUPP0   = 60;
   localparam int          EEC_PGS_SUPP1   = 63;
   localparam int          EEC_DS_EXPD_BIT = 2;
   localparam int          EEC_DS_CODE_BIT = 3;
   // Register map, byte addresses on the plain register port.
   localparam logic [3:0]  EEC_REG_CTRL    = 4'h0;
   localparam logic [3:0]  EEC_REG_STATUS  = 4'h4;
   localparam logic [3:0]  EEC_REG_COUNT   = 4'h8;
   localparam int          EEC_CTRL_XSAVE  = 0;
   localparam int          EEC_CTRL_ENABLE = 1;
   localparam logic [1:0]  EEC_CTRL_RESET  = 2'h3;

   typedef enum logic [3:0] {
      FC_NONE, FC_DS_SEG, FC_SEG_BASE, FC_TCS_ALIGN, FC_TCS_EPC, FC_AEP,
      FC_CONFLICT, FC_MAP, FC_OFFSETS, FC_FLAGS, FC_ENCLAVE_CONTROL_STRUCT, FC_MODE,
      FC_FEATURE, FC_NOTIFY, FC_TARGET, FC_DISABLED
   } eec_fault_e;

   // True when the upper address bits replicate the top implemented bit.
   function automatic logic eec_canon(input logic [63:0] a);
      eec_canon = (&a[63:EEC_VA_BITS-1]) || ~(|a[63:EEC_VA_BITS-1]);
   endfunction
endpackage

// file: test/eec_enclave_entry_checker_tb.sv
// Self-checking testbench for the enclave entry checker.
// Assumes the checker's own assertions sit in the design file and that
// the bench alone drives every request operand and the register port.
`timescale 1ns/100ps
module eec_enclave_entry_checker_tb;
   import eec_pkg::*;
   localparam logic [63:0] THREAD_CONTROL_STRUCT  = 64'h0000_0000_1000_0000;
   localparam logic [63:0] BASE = 64'h0000_0040_0000_0000;
   localparam logic [63:0] NCAN = 64'h0000_8000_0000_0000;
   localparam logic [30:0] PFM  = 31'h0000_03f2;
   logic        clk_i = 1'b0;
   logic        reset_i, reg_we_i, reg_re_i, entry_req_i, drain_done_i, exit_i, popf_tf_i;
   logic        efer_lma_i, cs_l_i, ds_unusable_i, ds_s_i, es_usable_i, ss_usable_i, ss_b_i;
   logic        tf_i, tcs_in_epc_i, tcs_busy_i, map_valid_i, map_blocked_i, map_pending_i;
   logic        map_modified_i, enclave_control_struct_present_i, enclave_control_struct_init_i, enclave_control_struct_wide_i, enclave_control_struct_notify_i;
   logic        os_fx_save_i, os_ext_save_i, gp, pf, sp, sh;
   logic [3:0]  reg_addr_i, ds_type_i;
   logic [7:0]  map_type_i;
   logic [31:0] reg_wdata_i, reg_rdata_o, cs_limit_i, v;
   logic [63:0] cs_base_i, ds_base_i, es_base_i, ss_base_i, tcs_ptr_i, aep_i, rsp_i, rbp_i;
   logic [63:0] fs_base_i, gs_base_i, map_addr_i, save_area_off_i, fs_base_off_i, gs_base_off_i;
   logic [63:0] entry_off_i, tcs_flags_i, enclave_control_struct_base_i, enclave_control_struct_feature_request_mask_i, xcr_i, pg, rip;
   logic        busy_o, hold_issue_o, tcs_share_o, done_o, fault_gp_o, fault_pf_o, tf_o;
   logic        enclave_mode_o, saved_tf_o, step_pend_o, bp_out_supp_o, bp_in_supp_o;
   logic        perf_supp_o, sample_off_o;
   logic [63:0] fault_addr_o, new_rip_o, ssa_rsp_o, ssa_rbp_o, tcs_aep_o, saved_fs_o, saved_gs_o;
   logic [63:0] fs_base_o, gs_base_o, xcr_o, saved_xcr_o, perf_gstat_set_o;
   int          n_fail = 0;
   int          check_count = 0;

   eec_enclave_entry_checker u_dut (.*);

   always #5 clk_i = ~clk_i;

   task automatic summarize;
      if (n_fail == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      check_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // A passing long-mode opt-out request; scenarios then break one field.
   task automatic base;
      {ds_unusable_i, ds_s_i, es_usable_i, ss_usable_i, ss_b_i, tcs_busy_i, map_blocked_i,
       map_pending_i, map_modified_i, enclave_control_struct_notify_i, exit_i, popf_tf_i, entry_req_i,
       reg_we_i, reg_re_i} <= '0;
      {efer_lma_i, cs_l_i, tcs_in_epc_i, map_valid_i, enclave_control_struct_present_i, enclave_control_struct_init_i,
       enclave_control_struct_wide_i, os_fx_save_i, os_ext_save_i, drain_done_i, tf_i} <= '1;
      {cs_base_i, ds_base_i, ss_base_i, tcs_flags_i} <= '0;
      es_base_i <= 64'h0000_0000_0000_0010;
      ds_type_i <= 4'h4;
      cs_limit_i <= 32'hffff_ffff;
      reg_addr_i <= 4'h0;
      reg_wdata_i <= 32'h0000_0000;
      tcs_ptr_i <= THREAD_CONTROL_STRUCT;
      map_addr_i <= THREAD_CONTROL_STRUCT;
      map_type_i <= EEC_PT_THREAD;
      aep_i <= 64'hffff_ffff_ffff_f000;
      rsp_i <= 64'h0000_0000_0000_7ff0;
      rbp_i <= 64'h0000_0000_0000_7ff8;
      fs_base_i <= 64'h0000_0000_0000_aa00;
      gs_base_i <= 64'h0000_0000_0000_bb00;
      save_area_off_i <= 64'h0000_0000_0000_2000;
      fs_base_off_i <= 64'h0000_0000_0000_3000;
      gs_base_off_i <= 64'h0000_0000_0000_4000;
      entry_off_i <= 64'h0000_0000_0000_0100;
      enclave_control_struct_base_i <= BASE;
      enclave_control_struct_feature_request_mask_i <= 64'h0000_0000_0000_0007;
      xcr_i <= 64'h0000_0000_0000_000f;
      // One edge passes so a scenario's overrides never share a time step with these.
      @(posedge clk_i);
   endtask

   task automatic nonlong;
      efer_lma_i <= 1'b0;
      enclave_control_struct_wide_i <= 1'b0;
      enclave_control_struct_base_i <= 64'h0000_0000_0010_0000;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_we_i <= 1'b1;
      @(posedge clk_i);
      reg_we_i <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_re_i <= 1'b1;
      @(posedge clk_i);
      reg_re_i <= 1'b0;
      #1 v = reg_rdata_o;
   endtask

   task automatic pulse(input bit ex);
      @(posedge clk_i);
      if (ex)
         exit_i <= 1'b1;
      else
         popf_tf_i <= 1'b1;
      @(posedge clk_i);
      {exit_i, popf_tf_i} <= 2'b00;
      repeat (2) @(posedge clk_i);
      #1;
   endtask

   // Pulse reports are gathered over the whole entry, one cycle past done.
   task automatic enter;
      int n;
      @(posedge clk_i);
      entry_req_i <= 1'b1;
      @(posedge clk_i);
      entry_req_i <= 1'b0;
      {sp, sh, pg} = '0;
      for (n = 0; n < 20; n++)
      begin
         #1;
         sp = sp | step_pend_o;
         sh = sh | tcs_share_o;
         pg = pg | perf_gstat_set_o;
         if (done_o === 1'b1)
            break;
         @(posedge clk_i);
      end
      gp = fault_gp_o;
      pf = fault_pf_o;
      if (n == 20)
      begin
         n_fail++;
         $display("[FAIL] done_o expected 1 seen 0");
         summarize;
      end
      @(posedge clk_i);
      #1;
      sp = sp | step_pend_o;
      pg = pg | perf_gstat_set_o;
   endtask

   task automatic t_optout;
      base;
      enter;
      chk("gp pf", 2'b00, {gp, pf});
      chk("share", 1'b1, sh);
      chk("mode", 1'b1, enclave_mode_o);
      chk("rip", BASE + 64'h100, new_rip_o);
      chk("ssa rsp", rsp_i, ssa_rsp_o);
      chk("ssa rbp", rbp_i, ssa_rbp_o);
      chk("aep", aep_i, tcs_aep_o);
      chk("saved fs", fs_base_i, saved_fs_o);
      chk("saved gs", gs_base_i, saved_gs_o);
      chk("fs", BASE + 64'h3000, fs_base_o);
      chk("gs", BASE + 64'h4000, gs_base_o);
      chk("xcr", enclave_control_struct_feature_request_mask_i, xcr_o);
      chk("saved xcr", xcr_i, saved_xcr_o);
      chk("tf", 2'b01, {tf_o, saved_tf_o});
      chk("step", 1'b0, sp);
      chk("bp", 2'b11, {bp_out_supp_o, bp_in_supp_o});
      chk("perf", 2'b11, {perf_supp_o, sample_off_o});
      chk("gstat", 64'h9000_0000_0000_0000, pg);
      pulse(1'b0);
      chk("tf popf", 1'b0, tf_o);
      pulse(1'b1);
      chk("exit tf", 2'b10, {tf_o, enclave_mode_o});
      chk("exit fs", fs_base_i, fs_base_o);
      chk("exit xcr", xcr_i, xcr_o);
   endtask

   // Opt-in, 32-bit, legacy save state: a wide exit pointer and a
   // mismatched notify flag are both legal here.
   task automatic t_optin;
      base;
      nonlong;
      tcs_flags_i <= 64'h0000_0000_0000_0003;
      os_ext_save_i <= 1'b0;
      enclave_control_struct_feature_request_mask_i <= EEC_FEATURE_REQUEST_MASK_LEGACY;
      aep_i <= NCAN;
      ss_usable_i <= 1'b1;
      ss_b_i <= 1'b1;
      enter;
      chk("gp pf", 2'b00, {gp, pf});
      chk("step", 1'b1, sp);
      chk("gstat", 64'h0, pg);
      chk("bp", 2'b10, {bp_out_supp_o, bp_in_supp_o});
      chk("perf", 1'b0, perf_supp_o);
      chk("xcr", xcr_i, xcr_o);
      chk("fs", 64'h0010_3000, fs_base_o);
      pulse(1'b1);
   endtask

   task automatic t_serial;
      int nd;
      base;
      drain_done_i <= 1'b0;
      @(posedge clk_i);
      entry_req_i <= 1'b1;
      @(posedge clk_i);
      entry_req_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      #1 chk("hold", 3'b110, {hold_issue_o, busy_o, done_o});
      entry_req_i <= 1'b1;
      @(posedge clk_i);
      entry_req_i <= 1'b0;
      drain_done_i <= 1'b1;
      nd = 0;
      repeat (12)
      begin
         @(posedge clk_i);
         #1 nd += int'(done_o);
      end
      chk("done count", 64'd1, 64'(nd));
      chk("hold end", 1'b0, hold_issue_o);
      pulse(1'b1);
   endtask

   task automatic t_faults;
      for (int k = 0; k < 31; k++)
      begin
         rip = new_rip_o;
         base;
         if (k >= 23)
            nonlong;
         case (k)
            0: tcs_ptr_i <= THREAD_CONTROL_STRUCT + 64'h8;
            1: tcs_in_epc_i <= 1'b0;
            2: aep_i <= NCAN;
            3: tcs_busy_i <= 1'b1;
            4: map_valid_i <= 1'b0;
            5: map_blocked_i <= 1'b1;
            6: map_pending_i <= 1'b1;
            7: map_modified_i <= 1'b1;
            8: map_addr_i <= THREAD_CONTROL_STRUCT + 64'h1000;
            9: map_type_i <= 8'h02;
            10: save_area_off_i <= 64'h2040;
            11: fs_base_off_i <= 64'h3800;
            12: gs_base_off_i <= 64'h4001;
            13: tcs_flags_i <= 64'h4;
            14: enclave_control_struct_present_i <= 1'b0;
            15: enclave_control_struct_init_i <= 1'b0;
            16: enclave_control_struct_wide_i <= 1'b0;
            17: os_fx_save_i <= 1'b0;
            18: xcr_i <= 64'h3;
            19: os_ext_save_i <= 1'b0;
            20: tcs_flags_i <= 64'h2;
            21: entry_off_i <= NCAN;
            22: cs_l_i <= 1'b0;
            23: ds_unusable_i <= 1'b1;
            24: ds_s_i <= 1'b1;
            25: cs_base_i <= 64'h1000;
            26: ss_usable_i <= 1'b1;
            27: es_usable_i <= 1'b1;
            28: ds_base_i <= 64'h1000;
            29: cs_limit_i <= 32'h0000_1000;
            default: wr(EEC_REG_CTRL, 32'h0000_0001);
         endcase
         enter;
         chk($sformatf("gp pf %0d", k), {~PFM[k], PFM[k]}, {gp, pf});
         chk("fault addr", PFM[k] ? tcs_ptr_i : 64'h0, fault_addr_o);
         chk("mode kept", 1'b0, enclave_mode_o);
         chk("rip kept", rip, new_rip_o);
         chk("xcr kept", xcr_i, xcr_o);
         if (k == 13)
         begin
            rd(EEC_REG_STATUS);
            chk("status", {FC_FLAGS, 4'h4}, v[7:0]);
         end
         if (k == 30)
         begin
            rd(EEC_REG_CTRL);
            chk("ctrl wr", 32'h0000_0001, v);
            wr(EEC_REG_CTRL, 32'h0000_0003);
         end
      end
   endtask

   initial
   begin
      reset_i = 1'b1;
      base;
      repeat (9) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(EEC_REG_CTRL);
      chk("ctrl", {30'h0, EEC_CTRL_RESET}, v);
      rd(4'hc);
      chk("unmapped", 32'h0, v);
      wr(EEC_REG_COUNT, 32'h0000_0010);
      t_optout;
      t_optin;
      t_serial;
      t_faults;
      rd(EEC_REG_COUNT);
      chk("count", 32'h0000_0013, v);
      summarize;
   end
endmodule // eec_enclave_entry_checker_tb
